// [hdl/ape_pkg.sv]
// Shared constants and types for the ancillary packet extractor
package ape_pkg;
  localparam int ADDR_W = 13;
  localparam logic [12:0] OFF_CTRL = 13'h0000;
  localparam logic [12:0] OFF_FEATURE = 13'h0004;
  localparam logic [12:0] OFF_LINE_FIRST = 13'h0008;
  localparam logic [12:0] OFF_LINE_SECOND = 13'h000C;
  localparam logic [12:0] OFF_TYPE_FIRST = 13'h0010;
  localparam logic [12:0] OFF_TYPE_LAST = 13'h0020;
  localparam logic [12:0] OFF_STATUS = 13'h0024;
  localparam logic [12:0] OFF_OVERFLOW = 13'h0028;
  localparam int BUF_SEL_BIT = 12;
  localparam int FEAT_W = 10;
  localparam int FEAT_ANC_EXT = 8;
  localparam int LINE_W = 11;
  localparam int WORD_W = 10;
  localparam int ENTRY_W = 16;
  localparam int BANK_AW = 10;
  localparam int BANK_DEPTH = 1024;
  localparam int NUM_BANKS = 2;
  localparam int NUM_TYPES = 5;
  localparam int NUM_CH = 2;
  localparam logic [9:0] ADF_FIRST = 10'h000;
  localparam logic [9:0] ADF_NEXT = 10'h3FF;
  localparam logic [9:0] BLANK_LUMA = 10'h040;
  localparam logic [9:0] BLANK_CHROMA = 10'h200;
  localparam logic [8:0] PKT_TAIL = 9'h006;
  localparam int PIPE_DEPTH = 5;
  localparam logic [FEAT_W-1:0] FEAT_RST = 10'h000;
  localparam logic [LINE_W-1:0] LINE_RST = 11'h000;

  typedef enum logic [1:0] {
    MODE_SD,
    MODE_HD,
    MODE_3GA,
    MODE_3GB
  } ape_mode_type;

  typedef struct packed {
    logic link_b_select;
    logic packet_delete_enable;
    logic both_channels_select;
    logic chroma_only_select;
    logic bank_toggle;
    logic extraction_disable;
  } ape_ctrl_type;

  typedef struct packed {
    logic [7:0] did;
    logic [7:0] sdid;
  } ape_filter_type;

  typedef struct packed {
    logic in_pkt;
    logic start;
    logic [9:0] word;
    logic [7:0] did;
    logic [7:0] sdid;
  } ape_pkt_type;

  localparam ape_ctrl_type CTRL_RST = 6'h00;
  localparam ape_filter_type FILT_RST = 16'h0000;
endpackage

// [hdl/ape_bank_ram.sv]
// One bank of extracted-word storage with registered read data
`timescale 1ns/1ps
module ape_bank_ram #(
  parameter int DEPTH = 1024,
  parameter int AW = 10,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// [hdl/ape_pkt_parser.sv]
// Per-channel ancillary packet finder with a short alignment pipeline
`timescale 1ns/1ps
module ape_pkt_parser (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] word_in,
  output ape_pkg::ape_pkt_type pkt
);
  import ape_pkg::*;

  logic [9:0] pipe_q [PIPE_DEPTH];
  logic busy_q;
  logic [8:0] pos_q;
  logic [7:0] dc_q;
  logic [7:0] did_q;
  logic [7:0] sdid_q;
  logic at_last;
  logic found;

  assign at_last = busy_q && (pos_q == PKT_TAIL + {1'b0, dc_q});
  // Flag found with DID in slot 0 and SDID arriving, so filters
  // are decided before the first flag word leaves the pipe
  assign found = (!busy_q || at_last) &&
                 pipe_q[3] == ADF_FIRST &&
                 pipe_q[2] == ADF_NEXT &&
                 pipe_q[1] == ADF_NEXT;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= 10'h000;
      end
    end else begin
      pipe_q[0] <= word_in;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      pos_q <= 9'h000;
      dc_q <= 8'h00;
      did_q <= 8'h00;
      sdid_q <= 8'h00;
    end else begin
      if (found) begin
        busy_q <= 1'b1;
        pos_q <= 9'h000;
        did_q <= pipe_q[0][7:0];
        sdid_q <= word_in[7:0];
      end else if (busy_q) begin
        if (at_last) begin
          busy_q <= 1'b0;
        end else begin
          pos_q <= pos_q + 9'h001;
        end
      end
      if (busy_q && pos_q == 9'h000) begin
        dc_q <= word_in[7:0];
      end
    end
  end

  assign pkt.in_pkt = busy_q;
  assign pkt.start = busy_q && pos_q == 9'h000;
  assign pkt.word = pipe_q[PIPE_DEPTH-1];
  assign pkt.did = did_q;
  assign pkt.sdid = sdid_q;
endmodule

// [hdl/ape_extractor.sv]
// Ancillary packet extractor with APB-readable two-bank store
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
// Operation
// - Two banks of 1024 sixteen-bit words
// - Store from first flag word onward
// - Find packets anywhere, active picture included
// - Luma low byte, chroma high byte
// - SD: luma only, upper byte zero
// - Zero filters capture all, else five
// - Two line registers; zero means unused
// - Enable starts next frame; disable stops
// - First fill goes into first bank
// - Toggle high writes the other bank
// - Toggle low clears old, exposes new
// - Fill until full, toggling alternates banks
// - Reset default: luma or stream one
// - Level B link choice, link A default
// - Chroma-only select; both-channels overrides it
// - Selects reset low, ignored in SD
// - Processing pin low stops capture, deletion
// - Delete replaces matching packets with blanking
// - Remaining packets stay where they are
// - Feature disable bits reset low
// - Processing only in standards mode
module ape_extractor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ape_pkg::ape_mode_type video_mode,
  input wire logic processing_enable_pin,
  input wire logic standards_bypass_n,
  input wire logic frame_start,
  input wire logic [10:0] line_number,
  input wire logic [9:0] luma_a_in,
  input wire logic [9:0] chroma_a_in,
  input wire logic [9:0] luma_b_in,
  input wire logic [9:0] chroma_b_in,
  output logic [9:0] luma_out,
  output logic [9:0] chroma_out,
  output logic luma_anc_flag,
  output logic chroma_anc_flag
);
  import ape_pkg::*;

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  ape_ctrl_type ctrl_q;
  logic [FEAT_W-1:0] feat_q;
  logic [LINE_W-1:0] line_first_q;
  logic [LINE_W-1:0] line_second_q;
  ape_filter_type filt_q [NUM_TYPES];
  logic ovf_q;
  logic run_q;
  logic tog_prev_q;
  logic wr_bank_q;
  logic rd_bank_q;
  logic [BANK_AW:0] ptr_q;
  logic clr_busy_q;
  logic clr_bank_q;
  logic [BANK_AW-1:0] clr_addr_q;

  logic access;
  logic first_acc;
  logic wr_take;
  logic aligned;
  logic is_buf;
  logic is_ctrl;
  logic is_feat;
  logic is_l1;
  logic is_l2;
  logic is_filt;
  logic is_stat;
  logic is_ovf;
  logic mapped;
  logic [2:0] filt_idx;
  logic [BANK_AW-1:0] buf_idx;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic [ENTRY_W-1:0] bank_rdata [NUM_BANKS];

  // Bus decode
  assign access = psel && penable;
  assign first_acc = access && !pready_q;
  assign wr_take = access && pready_q && pwrite;
  assign aligned = paddr[1:0] == 2'h0;
  assign is_buf = paddr[BUF_SEL_BIT] && aligned;
  assign is_ctrl = paddr == OFF_CTRL;
  assign is_feat = paddr == OFF_FEATURE;
  assign is_l1 = paddr == OFF_LINE_FIRST;
  assign is_l2 = paddr == OFF_LINE_SECOND;
  assign is_filt = aligned && paddr >= OFF_TYPE_FIRST &&
                   paddr <= OFF_TYPE_LAST;
  assign is_stat = paddr == OFF_STATUS;
  assign is_ovf = paddr == OFF_OVERFLOW;
  assign mapped = is_ctrl || is_feat || is_l1 || is_l2 || is_filt ||
                  is_stat || is_ovf || is_buf;
  assign filt_idx = 3'((paddr - OFF_TYPE_FIRST) >> 2);
  assign buf_idx = paddr[BANK_AW+1:2];

  assign status_word = {17'h00000, clr_busy_q, rd_bank_q, wr_bank_q,
                        run_q, ptr_q};

  // reads serve only the exposed bank
  assign rd_mux = is_ctrl ? {26'h0000000, ctrl_q} :
                  is_feat ? {22'h000000, feat_q} :
                  is_l1 ? {21'h000000, line_first_q} :
                  is_l2 ? {21'h000000, line_second_q} :
                  is_filt ? {16'h0000, filt_q[filt_idx]} :
                  is_stat ? status_word :
                  is_ovf ? {31'h00000000, ovf_q} :
                  is_buf ? {16'h0000, bank_rdata[rd_bank_q]} :
                  32'h00000000;

  // One wait state on every access lets bank data reach a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= first_acc;
      if (first_acc) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_q <= !mapped;
      end
    end
  end

  // Software registers
  logic ovf_clr;
  logic want_wr;
  logic full;
  assign ovf_clr = wr_take && is_ovf && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      feat_q <= FEAT_RST;
      line_first_q <= LINE_RST;
      line_second_q <= LINE_RST;
      ovf_q <= 1'b0;
    end else begin
      if (wr_take && is_ctrl) begin
        ctrl_q <= ape_ctrl_type'(pwdata[5:0]);
      end
      if (wr_take && is_feat) begin
        feat_q <= pwdata[FEAT_W-1:0];
      end
      if (wr_take && is_l1) begin
        line_first_q <= pwdata[LINE_W-1:0];
      end
      if (wr_take && is_l2) begin
        line_second_q <= pwdata[LINE_W-1:0];
      end
      // Lost word sets the flag even in the cycle it is cleared
      ovf_q <= (want_wr && full) || (ovf_q && !ovf_clr);
    end
  end

  logic [NUM_TYPES-1:0] filt_nz;
  logic filt_any;
  genvar t;
  generate
    for (t = 0; t < NUM_TYPES; t++) begin : g_filt
      ape_filter_type filt_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_r <= FILT_RST;
        end else if (wr_take && is_filt && filt_idx == 3'(t)) begin
          filt_r <= ape_filter_type'(pwdata[15:0]);
        end
      end
      assign filt_q[t] = filt_r;
      assign filt_nz[t] = |filt_r;
    end
  endgenerate
  assign filt_any = |filt_nz;

  // A zero SDID in a filter entry matches on DID alone
  function automatic logic type_hit(input logic [7:0] did,
                                    input logic [7:0] sdid);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TYPES; i++) begin
      if (filt_nz[i] && filt_q[i].did == did &&
          (filt_q[i].sdid == 8'h00 || filt_q[i].sdid == sdid)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Gating and selection
  logic proc_path;
  logic ext_ok;
  logic sd_mode;
  logic link_b;
  logic line_ok;
  logic [NUM_CH-1:0] ch_use;
  logic [9:0] ch_in [NUM_CH];
  logic [9:0] blank [NUM_CH];

  assign proc_path = processing_enable_pin && standards_bypass_n;
  assign ext_ok = proc_path && !feat_q[FEAT_ANC_EXT] &&
                  !ctrl_q.extraction_disable;
  assign sd_mode = video_mode == MODE_SD;
  assign link_b = video_mode == MODE_3GB && ctrl_q.link_b_select;
  assign ch_in[0] = link_b ? luma_b_in : luma_a_in;
  assign ch_in[1] = link_b ? chroma_b_in : chroma_a_in;
  assign blank[0] = BLANK_LUMA;
  assign blank[1] = BLANK_CHROMA;
  assign ch_use[0] = sd_mode || ctrl_q.both_channels_select ||
                     !ctrl_q.chroma_only_select;
  assign ch_use[1] = !sd_mode && (ctrl_q.both_channels_select ||
                                  ctrl_q.chroma_only_select);
  assign line_ok = (line_first_q == LINE_RST &&
                    line_second_q == LINE_RST) ||
                   (line_first_q != LINE_RST &&
                    line_number == line_first_q) ||
                   (line_second_q != LINE_RST &&
                    line_number == line_second_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (!ext_ok) begin
      run_q <= 1'b0;
    end else if (frame_start) begin
      run_q <= 1'b1;
    end
  end

  // Per-channel packet handling
  ape_pkt_type pkt [NUM_CH];
  logic [NUM_CH-1:0] cap_cur;
  logic [NUM_CH-1:0] flag_vec;
  logic [9:0] out_arr [NUM_CH];
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      logic hit;
      logic del_cur;
      logic cap_r;
      logic del_r;
      logic flag_r;
      logic [9:0] out_r;
      ape_pkt_parser u_parser (
        .clk(pclk),
        .rstn(presetn),
        .word_in(ch_in[c]),
        .pkt(pkt[c])
      );
      assign hit = !filt_any || type_hit(pkt[c].did, pkt[c].sdid);
      assign cap_cur[c] = pkt[c].start ?
                          (run_q && ch_use[c] && line_ok && hit) : cap_r;
      assign del_cur = pkt[c].start ?
                       (proc_path && ctrl_q.packet_delete_enable && hit) :
                       del_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cap_r <= 1'b0;
          del_r <= 1'b0;
          flag_r <= 1'b0;
          out_r <= 10'h000;
        end else begin
          cap_r <= cap_cur[c];
          del_r <= del_cur;
          flag_r <= pkt[c].in_pkt;
          // pin low stops a deletion already under way
          out_r <= (pkt[c].in_pkt && del_cur && proc_path) ? blank[c] :
                   pkt[c].word;
        end
      end
      assign flag_vec[c] = flag_r;
      assign out_arr[c] = out_r;
    end
  endgenerate

  // Word assembly
  logic cap_y;
  logic cap_c;
  logic we_cap;
  logic [ENTRY_W-1:0] entry;
  assign cap_y = pkt[0].in_pkt && cap_cur[0];
  assign cap_c = pkt[1].in_pkt && cap_cur[1];
  assign want_wr = (cap_y || cap_c) && run_q;
  assign full = ptr_q[BANK_AW];
  assign we_cap = want_wr && !full;
  assign entry = {cap_c ? pkt[1].word[7:0] : 8'h00,
                  cap_y ? pkt[0].word[7:0] : 8'h00};

  // Bank sequencing
  logic tog_rise;
  logic tog_fall;
  logic clr_last;
  assign tog_rise = ctrl_q.bank_toggle && !tog_prev_q;
  assign tog_fall = !ctrl_q.bank_toggle && tog_prev_q;
  assign clr_last = clr_addr_q == {BANK_AW{1'b1}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_prev_q <= 1'b0;
      wr_bank_q <= 1'b0;
      rd_bank_q <= 1'b0;
      ptr_q <= '0;
      clr_busy_q <= 1'b0;
      clr_bank_q <= 1'b0;
      clr_addr_q <= '0;
    end else begin
      tog_prev_q <= ctrl_q.bank_toggle;
      if (tog_rise && !ctrl_q.extraction_disable) begin
        wr_bank_q <= !rd_bank_q;
        ptr_q <= '0;
      end else if (we_cap) begin
        ptr_q <= ptr_q + 1'b1;
      end
      if (tog_fall && rd_bank_q != wr_bank_q) begin
        rd_bank_q <= wr_bank_q;
        clr_busy_q <= 1'b1;
        clr_bank_q <= rd_bank_q;
        clr_addr_q <= '0;
      end else if (clr_busy_q) begin
        clr_addr_q <= clr_addr_q + 1'b1;
        if (clr_last) begin
          clr_busy_q <= 1'b0;
        end
      end
    end
  end

  // Clearing takes a full bank pass; capture meanwhile uses the other
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic clr_here;
      logic we;
      assign clr_here = clr_busy_q && clr_bank_q == 1'(b);
      assign we = clr_here || (we_cap && wr_bank_q == 1'(b));
      ape_bank_ram #(
        .DEPTH(BANK_DEPTH),
        .AW(BANK_AW),
        .DW(ENTRY_W)
      ) u_ram (
        .clk(pclk),
        .we(we),
        .waddr(clr_here ? clr_addr_q : ptr_q[BANK_AW-1:0]),
        .wdata(clr_here ? {ENTRY_W{1'b0}} : entry),
        .raddr(buf_idx),
        .rdata(bank_rdata[b])
      );
    end
  endgenerate

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign luma_out = out_arr[0];
  assign chroma_out = out_arr[1];
  assign luma_anc_flag = flag_vec[0];
  assign chroma_anc_flag = flag_vec[1];
endmodule

// [test/ape_extractor_assertions.sv]
// Port-level assertions for the ancillary packet extractor
`timescale 1ns/1ps
module ape_extractor_checker
  import ape_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ape_pkg::ape_mode_type video_mode,
  input wire logic processing_enable_pin,
  input wire logic standards_bypass_n,
  input wire logic [9:0] luma_a_in,
  input wire logic [9:0] chroma_a_in,
  input wire logic [9:0] luma_out,
  input wire logic [9:0] chroma_out,
  input wire logic luma_anc_flag,
  input wire logic chroma_anc_flag
);
  logic [2:0] up_q;
  logic [3:0] quiet_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The pipeline still holds reset zeros for a few cycles after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_q <= 4'h0;
    else if (processing_enable_pin && standards_bypass_n) quiet_q <= 4'h0;
    else if (quiet_q != 4'h8) quiet_q <= quiet_q + 4'h1;
  end
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_unaligned: assert property (psel && penable && !pready &&
      paddr[1:0] != 2'b00 |=> pready && pslverr)
    else $error("unaligned access not refused");
  a_zero_data: assert property (pready && (pwrite || pslverr) |->
      prdata == 32'h0000_0000)
    else $error("read data not zero");
  a_pass_through: assert property (
      quiet_q == 4'h8 && video_mode != MODE_3GB |->
      luma_out == $past(luma_a_in, 6) && chroma_out == $past(chroma_a_in, 6))
    else $error("stream altered while processing is off");
  a_luma_blank: assert property (
      up_q == 3'h7 && video_mode == MODE_HD &&
      $past(video_mode, 6) == MODE_HD && luma_out != $past(luma_a_in, 6)
      |-> luma_out == BLANK_LUMA)
    else $error("luma word changed to a non-blank value");
  a_flag_adf: assert property (
      $rose(luma_anc_flag) |-> $past(luma_a_in, 6) == ADF_FIRST)
    else $error("luma flag not aligned to flag word");
  a_chroma_adf: assert property (
      $rose(chroma_anc_flag) |-> $past(chroma_a_in, 6) == ADF_FIRST)
    else $error("chroma flag not aligned to flag word");
  a_flag_span: assert property (
      $rose(luma_anc_flag) |-> luma_anc_flag [*7])
    else $error("luma flag shorter than a packet");
  cover property ($rose(luma_anc_flag));
  cover property (pready && pslverr);
  cover property (quiet_q == 4'h8);
endmodule
bind ape_extractor ape_extractor_checker u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .video_mode,
  .processing_enable_pin, .standards_bypass_n, .luma_a_in, .chroma_a_in,
  .luma_out, .chroma_out, .luma_anc_flag, .chroma_anc_flag);

// [test/ape_host.sv]
// Host processor model: APB master reaching the extractor registers
`timescale 1ns/1ps
module ape_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [12:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 13'h0000;
    pwdata = 32'h0000_0000;
  end
  // one APB transfer, read or write, giving up after 64 cycles of waiting for pready
  task automatic xfer(input logic w, input logic [12:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e,
      output logic to);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 64) begin
      n++;
      @(posedge pclk);
    end
    to = (n == 64);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the ancillary packet extractor
`timescale 1ns/1ps
module testbench;
  import ape_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, re, to, lf, cf;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  ape_mode_type mode = MODE_HD;
  logic pin_en = 1'b1;
  logic std_n = 1'b1;
  logic fs = 1'b0;
  logic [10:0] line = 11'h000;
  logic [9:0] la = 10'h040;
  logic [9:0] ca = 10'h200;
  logic [9:0] lo, co;
  logic [7:0] d, prev;
  logic [10:0] ptr = 11'h000;
  logic [12:0] ra [5];
  int bad_count = 0;
  int comparisons = 0;
  int seed = 32'h6219;

  ape_extractor DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .video_mode(mode), .processing_enable_pin(pin_en),
    .standards_bypass_n(std_n), .frame_start(fs), .line_number(line),
    .luma_a_in(la), .chroma_a_in(ca), .luma_b_in(10'h040),
    .chroma_b_in(10'h200), .luma_out(lo), .chroma_out(co),
    .luma_anc_flag(lf), .chroma_anc_flag(cf));
  ape_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial forever #10 pclk = ~pclk;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [12:0] a,
      input logic [31:0] v);
    host.xfer(w, a, v, rv, re, to);
    if (to) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [12:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [31:0] ent(input logic [7:0] v, input bit hi);
    return hi ? {16'h0000, v, 8'h00} : {24'h000000, v};
  endfunction
  task automatic see(input logic [10:0] i, input logic [31:0] e);
    rd({1'b1, i[9:0], 2'b00});
    chk(rv, e);
  endtask
  task automatic frame();
    @(posedge pclk);
    fs <= 1'b1;
    @(posedge pclk);
    fs <= 1'b0;
  endtask
  // Drives one packet and checks the delayed output stream
  task automatic send(input logic [7:0] v, input bit hi, input int how);
    logic [9:0] w [0:9];
    logic [9:0] idle;
    idle = hi ? BLANK_CHROMA : BLANK_LUMA;
    w = '{ADF_FIRST, ADF_NEXT, ADF_NEXT, {2'b10, v}, 10'h201, 10'h202,
      10'h155, 10'h0AA, 10'h1C3, idle};
    for (int k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (hi) ca <= (k < 10) ? w[k] : idle;
      else la <= (k < 10) ? w[k] : idle;
      @(negedge pclk);
      if (k >= 6) begin
        chk({22'h0, (hi ? co : lo)}, {22'h0, (how == 1) ? idle : w[k-6]});
        if (how != 1) chk({31'h0, (hi ? cf : lf)}, {31'h0, (k < 15)});
      end
    end
  endtask
  task automatic cap(input logic [7:0] v, input bit hi, input int how,
      input bit taken);
    send(v, hi, how);
    if (taken) ptr = ptr + 11'h009;
    rd(OFF_STATUS);
    chk({21'h0, rv[10:0]}, {21'h0, ptr});
  endtask
  task automatic wait_clear();
    int n;
    n = 0;
    rd(OFF_STATUS);
    while (rv[14] !== 1'b0 && n < 400) begin
      n++;
      rd(OFF_STATUS);
    end
    if (n == 400) begin
      bad_count++;
      wrap_up();
    end
  endtask

  initial begin
    ra = '{OFF_CTRL, OFF_FEATURE, OFF_LINE_FIRST, OFF_LINE_SECOND,
      OFF_TYPE_FIRST};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(rv, 32'h0000_0000);
    end
    rd(13'h0030);
    chk({31'h0, re}, 32'h0000_0001);
    rd(13'h0002);
    chk({31'h0, re}, 32'h0000_0001);
    $display("test register defaults done");
    frame();
    d = 8'($random(seed));
    cap(d, 1'b0, 0, 1'b1);
    see(11'h000, 32'h0000_0000);
    see(11'h001, ent(8'hFF, 1'b0));
    see(11'h003, ent(d, 1'b0));
    prev = d;
    for (int r = 0; r < 2; r++) begin
      // toggled only while both flags are low
      wr(OFF_CTRL, 32'h0000_0002);
      ptr = 11'h000;
      d = 8'($random(seed));
      cap(d, 1'b0, 0, 1'b1);
      see(11'h003, ent(prev, 1'b0));
      wr(OFF_CTRL, 32'h0000_0000);
      wait_clear();
      see(11'h003, ent(d, 1'b0));
      prev = d;
    end
    $display("test bank switching done");
    wr(OFF_CTRL, 32'h0000_0004);
    cap(d, 1'b1, 2, 1'b1);
    see(ptr - 11'h006, ent(d, 1'b1));
    cap(d, 1'b0, 2, 1'b0);
    wr(OFF_CTRL, 32'h0000_000C);
    cap(d, 1'b0, 2, 1'b1);
    see(ptr - 11'h006, ent(d, 1'b0));
    @(posedge pclk);
    mode <= MODE_SD;
    ca <= 10'h155;
    cap(d, 1'b1, 2, 1'b0);
    cap(d, 1'b0, 2, 1'b1);
    see(ptr - 11'h006, ent(d, 1'b0));
    $display("test channel select done");
    @(posedge pclk);
    mode <= MODE_3GA;
    ca <= BLANK_CHROMA;
    wr(OFF_CTRL, 32'h0000_0000);
    cap(d, 1'b0, 0, 1'b1);
    mode <= MODE_3GB;
    cap(d, 1'b0, 0, 1'b1);
    // Link B lanes stay idle, so link A packets must vanish
    wr(OFF_CTRL, 32'h0000_0020);
    cap(d, 1'b0, 1, 1'b0);
    @(posedge pclk);
    mode <= MODE_HD;
    wr(OFF_CTRL, 32'h0000_0001);
    cap(d, 1'b0, 0, 1'b0);
    wr(OFF_CTRL, 32'h0000_0000);
    cap(d, 1'b0, 0, 1'b0);
    frame();
    wr(OFF_LINE_FIRST, 32'h0000_0005);
    @(posedge pclk);
    line <= 11'h007;
    cap(d, 1'b0, 0, 1'b0);
    @(posedge pclk);
    line <= 11'h005;
    cap(d, 1'b0, 0, 1'b1);
    wr(OFF_LINE_FIRST, 32'h0000_0000);
    $display("test enable and lines done");
    wr(OFF_TYPE_FIRST, 32'h0000_6100);
    wr(OFF_CTRL, 32'h0000_0010);
    cap(8'h62, 1'b0, 2, 1'b0);
    cap(8'h61, 1'b0, 1, 1'b1);
    @(posedge pclk);
    pin_en <= 1'b0;
    frame();
    cap(8'h61, 1'b0, 2, 1'b0);
    @(posedge pclk);
    pin_en <= 1'b1;
    std_n <= 1'b0;
    frame();
    cap(8'h61, 1'b0, 2, 1'b0);
    $display("test deletion and gating done");
    wrap_up();
  end
endmodule
